// File: inc/aoss_pkg.sv
// Shared constants, register map and carrier types for one analog output channel controller.
// Assumes a single 125 MHz clock and output codes on a 16-bit unsigned full-scale span.
`default_nettype none

package aoss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int AOSS_CLK_NS = 8;
  localparam int AOSS_TICK_NS = 1_000_000;
  localparam int AOSS_TICK_CYCLES = AOSS_TICK_NS / AOSS_CLK_NS;
  localparam int AOSS_TICKS_PER_SEC = 1_000_000_000 / AOSS_TICK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] AOSS_CONFIG_ADDR = 8'h00;
  localparam logic [7:0] AOSS_SLEW_ADDR = 8'h04;
  localparam logic [7:0] AOSS_FAULT_VAL_ADDR = 8'h08;
  localparam logic [7:0] AOSS_PROG_VAL_ADDR = 8'h0C;
  localparam logic [7:0] AOSS_FINAL_VAL_ADDR = 8'h10;
  localparam logic [7:0] AOSS_UPDATE_IV_ADDR = 8'h14;
  localparam logic [7:0] AOSS_STATUS_ADDR = 8'h18;
  localparam logic [7:0] AOSS_UNLATCH_ADDR = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // Range codes
  localparam logic [2:0] AOSS_RANGE_BIPOLAR_10V = 3'h0;
  localparam logic [2:0] AOSS_RANGE_0_5V = 3'h1;
  localparam logic [2:0] AOSS_RANGE_0_10V = 3'h2;
  localparam logic [2:0] AOSS_RANGE_0_20MA = 3'h4;
  localparam logic [2:0] AOSS_RANGE_4_20MA = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Values and reset figures
  localparam logic [15:0] AOSS_FULL_SCALE = 16'hFFFF;
  localparam logic [15:0] AOSS_MATCH_CODES = 16'h0041;
  localparam logic [31:0] AOSS_SLEW_RESET = 32'h000F4240;
  localparam logic [15:0] AOSS_UI_RESET = 16'h0001;
  localparam logic [3:0] AOSS_HOLD_1S = 4'h1;
  localparam logic [3:0] AOSS_HOLD_2S = 4'h2;
  localparam logic [3:0] AOSS_HOLD_5S = 4'h5;
  localparam logic [3:0] AOSS_HOLD_10S = 4'hA;

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_PROG, ST_FAULT, ST_FINAL} aoss_state_e_t;

  // Configuration word, LSB first: range[2:0] ... fault_hold_time[18:15]
  typedef struct packed {
    logic [3:0] fault_hold_time;
    logic hold_until_match;
    logic fault_ramp_on;
    logic program_ramp_on;
    logic run_ramp_on;
    logic program_to_fault_on;
    logic program_action;
    logic fault_action;
    logic chan_disable;
    logic open_load_check_on;
    logic ramp_alarm_latch_on;
    logic limit_alarm_latch_on;
    logic alarm_suppress;
    logic [2:0] range;
  } aoss_cfg_t;

  localparam aoss_cfg_t AOSS_CFG_RESET = 19'h00208;

  // Cyclic data and mode from the controller connection
  typedef struct packed {
    logic ctrl_run;
    logic conn_ok;
    logic conn_inhibit;
    logic field_side_power;
    logic [15:0] cmd_value;
  } aoss_link_t;

  typedef struct packed {
    aoss_state_e_t st;
    logic [15:0] out;
    logic [2:0] out_range;
    logic out_enable;
    logic limit_alarm;
    logic ramp_alarm;
    logic open_load_alarm;
    logic open_load_run;
    logic init_hold;
    logic [19:0] tick_cnt;
    logic [13:0] fault_cnt;
    logic prev_conn;
    logic prev_run;
    logic prev_power;
    aoss_cfg_t cfg;
    logic [31:0] max_slew;
    logic [15:0] fault_val;
    logic [15:0] prog_val;
    logic [15:0] final_val;
    logic [15:0] update_iv;
    logic unlatch_limit;
    logic unlatch_ramp;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } aoss_state_t;

  localparam aoss_state_t AOSS_STATE_RESET = '{st: ST_IDLE, cfg: AOSS_CFG_RESET, max_slew: AOSS_SLEW_RESET,
                                               update_iv: AOSS_UI_RESET, default: '0};

endpackage

`default_nettype wire

// File: verilog/aoss_chan.sv
// Safe-state, ramp and hold-until-match control for one analog output channel, with an APB register slave.
// Assumes link inputs synchronous to pclk; limit_hit and open_load_seen come from the clamp and field stages.
//
// Our own choices: the placing of the registers and the APB register port.
`default_nettype none

// What this block does
// - Range code selects one of five output ranges
// - Suppress bit set blocks limit and ramp alarms
// - Latched limit alarm holds until unlatched
// - Latched ramp alarm holds until unlatched
// - Open-load check runs only when enabled
// - Disable bit set turns the channel off
// - Connection fault holds or drives fault value
// - Program or inhibit holds or drives program value
// - Fault during Program stays there or faults
// - Run-mode changes limited by ramp rate when enabled
// - Ramp into Program state when enabled
// - Ramp toward fault and final values when enabled
// - Hold output after init events until match
// - Without hold, drive commanded value immediately
// - Fault duration zero or unknown code holds forever, else final
// - Ramp rate in units per second, default million
// - Rate zero ramps full scale per update interval
// - Fault action zero drives fault value
// - Expired fault duration drives final fault value
// - Program action zero drives program value
module aoss_chan #(
  parameter int TICK_CYCLES = aoss_pkg::AOSS_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire aoss_pkg::aoss_link_t link,
  input wire logic limit_hit,
  input wire logic open_load_seen,
  output logic [15:0] out_value,
  output logic [2:0] out_range,
  output logic out_enable,
  output logic limit_alarm,
  output logic ramp_alarm,
  output logic open_load_alarm,
  output logic open_load_run
);
  import aoss_pkg::*;

  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

  aoss_state_t q;
  aoss_state_t n;
  logic tick;
  logic acc;
  logic hit;
  logic init_evt;
  logic match;
  logic ramp_en;
  logic [15:0] target;
  logic [15:0] gap;
  logic [15:0] step;
  logic [15:0] ui_nz;
  logic [31:0] rate_step;
  logic [31:0] full_step;
  logic [31:0] step_raw;
  logic [13:0] hold_ticks;
  logic [31:0] rd_word;

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    tick = (q.tick_cnt >= TICK_LAST);
    n.tick_cnt = tick ? 20'h00000 : q.tick_cnt + 20'h00001;

    // Step per tick; slow rates round to one code since a fraction cannot be kept
    ui_nz = (q.update_iv == 16'h0000) ? 16'h0001 : q.update_iv;
    rate_step = q.max_slew / 32'(AOSS_TICKS_PER_SEC);
    full_step = {16'h0000, AOSS_FULL_SCALE} / {16'h0000, ui_nz};
    step_raw = (q.max_slew == 32'h00000000) ? full_step : rate_step;
    if (step_raw > 32'h0000FFFF) begin
      step = 16'hFFFF;
    end else if (step_raw == 32'h00000000) begin
      step = 16'h0001;
    end else begin
      step = step_raw[15:0];
    end

    // APB: one wait state, write lands on the completing edge
    acc = psel & penable;
    n.pready = acc & ~q.pready;
    n.pslverr = 1'b0;
    n.unlatch_limit = 1'b0;
    n.unlatch_ramp = 1'b0;
    hit = 1'b1;
    rd_word = 32'h00000000;
    case (paddr)
      AOSS_CONFIG_ADDR: rd_word = {13'h0000, q.cfg};
      AOSS_SLEW_ADDR: rd_word = q.max_slew;
      AOSS_FAULT_VAL_ADDR: rd_word = {16'h0000, q.fault_val};
      AOSS_PROG_VAL_ADDR: rd_word = {16'h0000, q.prog_val};
      AOSS_FINAL_VAL_ADDR: rd_word = {16'h0000, q.final_val};
      AOSS_UPDATE_IV_ADDR: rd_word = {16'h0000, q.update_iv};
      AOSS_STATUS_ADDR: rd_word = {q.out, 9'h000, q.init_hold, q.open_load_alarm, q.ramp_alarm,
                                   q.limit_alarm, q.st};
      AOSS_UNLATCH_ADDR: rd_word = 32'h00000000;
      default: hit = 1'b0;
    endcase
    if (acc && !q.pready) begin
      n.pslverr = ~hit;
      n.prdata = pwrite ? 32'h00000000 : rd_word;
    end
    if (acc && q.pready && pwrite) begin
      case (paddr)
        AOSS_CONFIG_ADDR: n.cfg = pwdata[18:0];
        AOSS_SLEW_ADDR: n.max_slew = pwdata;
        AOSS_FAULT_VAL_ADDR: n.fault_val = pwdata[15:0];
        AOSS_PROG_VAL_ADDR: n.prog_val = pwdata[15:0];
        AOSS_FINAL_VAL_ADDR: n.final_val = pwdata[15:0];
        AOSS_UPDATE_IV_ADDR: n.update_iv = pwdata[15:0];
        AOSS_UNLATCH_ADDR: begin
          n.unlatch_limit = pwdata[0];
          n.unlatch_ramp = pwdata[1];
        end
        default: n.max_slew = q.max_slew;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault duration in ticks; unknown codes behave as forever
    case (q.cfg.fault_hold_time)
      AOSS_HOLD_1S: hold_ticks = 14'(1 * AOSS_TICKS_PER_SEC);
      AOSS_HOLD_2S: hold_ticks = 14'(2 * AOSS_TICKS_PER_SEC);
      AOSS_HOLD_5S: hold_ticks = 14'(5 * AOSS_TICKS_PER_SEC);
      AOSS_HOLD_10S: hold_ticks = 14'(10 * AOSS_TICKS_PER_SEC);
      default: hold_ticks = 14'h0000;
    endcase

    // Inhibit is deliberate, so it counts as Program rather than a fault
    if (link.conn_inhibit) begin
      n.st = ST_PROG;
    end else if (!link.conn_ok) begin
      case (q.st)
        ST_IDLE: n.st = ST_IDLE;
        ST_PROG: begin
          if (q.cfg.program_to_fault_on) begin
            n.st = ST_FAULT;
            n.fault_cnt = 14'h0000;
          end
        end
        ST_FAULT: begin
          if (tick && hold_ticks != 14'h0000) begin
            if (q.fault_cnt + 14'h0001 >= hold_ticks) begin
              n.st = ST_FINAL;
            end else begin
              n.fault_cnt = q.fault_cnt + 14'h0001;
            end
          end
        end
        ST_FINAL: n.st = ST_FINAL;
        default: begin
          n.st = ST_FAULT;
          n.fault_cnt = 14'h0000;
        end
      endcase
    end else begin
      n.st = link.ctrl_run ? ST_RUN : ST_PROG;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Initialization events: connect, Program to Run, power back
    init_evt = (link.conn_ok & ~q.prev_conn) | (link.field_side_power & ~q.prev_power) |
               (link.conn_ok & link.ctrl_run & ~q.prev_run);
    n.prev_conn = link.conn_ok;
    n.prev_run = link.ctrl_run & link.conn_ok;
    n.prev_power = link.field_side_power;
    match = absdiff(link.cmd_value, q.out) <= AOSS_MATCH_CODES;
    if (init_evt && q.cfg.hold_until_match) begin
      n.init_hold = 1'b1;
    end else if (match || !q.cfg.hold_until_match) begin
      n.init_hold = 1'b0;
    end

    case (q.st)
      ST_RUN: begin
        target = q.init_hold ? q.out : link.cmd_value;
        ramp_en = q.cfg.run_ramp_on;
      end
      ST_PROG: begin
        target = q.cfg.program_action ? q.out : q.prog_val;
        ramp_en = q.cfg.program_ramp_on;
      end
      ST_FAULT: begin
        target = q.cfg.fault_action ? q.out : q.fault_val;
        ramp_en = q.cfg.fault_ramp_on;
      end
      ST_FINAL: begin
        target = q.final_val;
        ramp_en = q.cfg.fault_ramp_on;
      end
      default: begin
        target = q.out;
        ramp_en = 1'b0;
      end
    endcase

    // Ramp always starts from the present output, so a new target never jumps
    gap = absdiff(target, q.out);
    if (q.cfg.chan_disable) begin
      n.out = 16'h0000;
    end else if (!ramp_en || gap <= step) begin
      n.out = (ramp_en && !tick) ? q.out : target;
    end else if (tick) begin
      n.out = (target > q.out) ? q.out + step : q.out - step;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alarms: a new raise wins over an unlatch in the same cycle
    n.ramp_alarm = ~q.cfg.alarm_suppress &
                   ((ramp_en & (gap > step)) | (q.ramp_alarm & q.cfg.ramp_alarm_latch_on & ~q.unlatch_ramp));
    n.limit_alarm = ~q.cfg.alarm_suppress &
                    (limit_hit | (q.limit_alarm & q.cfg.limit_alarm_latch_on & ~q.unlatch_limit));
    n.open_load_run = q.cfg.open_load_check_on & ~q.cfg.chan_disable;
    n.open_load_alarm = q.open_load_run & open_load_seen;
    n.out_range = q.cfg.range;
    case (q.cfg.range)
      AOSS_RANGE_BIPOLAR_10V, AOSS_RANGE_0_5V, AOSS_RANGE_0_10V,
      AOSS_RANGE_0_20MA, AOSS_RANGE_4_20MA: n.out_enable = ~q.cfg.chan_disable;
      default: n.out_enable = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= AOSS_STATE_RESET;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign out_value = q.out;
  assign out_range = q.out_range;
  assign out_enable = q.out_enable;
  assign limit_alarm = q.limit_alarm;
  assign ramp_alarm = q.ramp_alarm;
  assign open_load_alarm = q.open_load_alarm;
  assign open_load_run = q.open_load_run;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_disable_zero: assert property (q.cfg.chan_disable |=> q.out == 16'h0000 && !q.out_enable)
    else $error("disabled channel still drives");
  chk_suppress_alarms: assert property (q.cfg.alarm_suppress |=> !q.limit_alarm && !q.ramp_alarm)
    else $error("alarm raised while suppressed");
  chk_limit_latch: assert property ((q.limit_alarm && q.cfg.limit_alarm_latch_on && !q.unlatch_limit
                                     && !q.cfg.alarm_suppress) |=> q.limit_alarm)
    else $error("latched limit alarm dropped");
  chk_open_load_gate: assert property (!q.cfg.open_load_check_on |=> ##1 !q.open_load_alarm)
    else $error("open-load alarm while check off");
  chk_prog_value: assert property ((q.st == ST_PROG && !q.cfg.program_action && !q.cfg.program_ramp_on
                                    && !q.cfg.chan_disable) |=> q.out == $past(q.prog_val))
    else $error("program value not driven");
  chk_prog_hold: assert property ((q.st == ST_PROG && q.cfg.program_action && !q.cfg.chan_disable)
                                  |=> $stable(q.out))
    else $error("output moved in program hold");
  chk_fault_value: assert property ((q.st == ST_FAULT && !q.cfg.fault_action && !q.cfg.fault_ramp_on
                                     && !q.cfg.chan_disable) |=> q.out == $past(q.fault_val))
    else $error("fault value not driven");
  chk_final_value: assert property ((q.st == ST_FINAL && !q.cfg.fault_ramp_on && !q.cfg.chan_disable)
                                    |=> q.out == $past(q.final_val))
    else $error("final fault value not driven");
  chk_prog_no_final: assert property ((q.st == ST_PROG && !q.cfg.program_to_fault_on && !link.conn_inhibit)
                                      |=> q.st != ST_FINAL && q.st != ST_FAULT)
    else $error("left program state on fault");
  chk_forever_hold: assert property ((q.st == ST_FAULT && q.cfg.fault_hold_time == 4'h0 && !link.conn_ok
                                      && !link.conn_inhibit) |=> q.st == ST_FAULT)
    else $error("fault state ended with forever hold");
  chk_ramp_step: assert property ((q.st == ST_RUN && q.cfg.run_ramp_on && !q.cfg.chan_disable)
                                  |=> absdiff(q.out, $past(q.out)) <= $past(step))
    else $error("run step exceeds ramp limit");
  chk_init_hold: assert property ((q.st == ST_RUN && q.init_hold && !q.cfg.chan_disable) |=> $stable(q.out))
    else $error("output moved before init match");

  cov_final: cover property (q.st == ST_FAULT ##1 q.st == ST_FINAL);
  cov_prog_to_fault: cover property (q.st == ST_PROG ##1 q.st == ST_FAULT);
  cov_init_release: cover property (q.init_hold ##1 !q.init_hold);
  cov_ramp_alarm: cover property (q.ramp_alarm && q.st == ST_RUN);

endmodule // aoss_chan

`default_nettype wire

// File: dv/aoss_ctrl_model.sv
// Controller model: drives run/program mode, connection state and command data.
// Assumes the bench calls put() from its main sequence; link changes just after a rising edge.
`default_nettype none

module aoss_ctrl_model (
  input wire logic pclk,
  output var aoss_pkg::aoss_link_t link
);
  timeunit 1ns;
  timeprecision 1ps;
  import aoss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Starts disconnected so the first connect is a real rising edge
  initial link = '0;

  task automatic put(input logic run, input logic ok, input logic inh, input logic [15:0] cmd);
    @(posedge pclk);
    link <= '{ctrl_run: run, conn_ok: ok, conn_inhibit: inh, field_side_power: 1'b1, cmd_value: cmd};
  endtask
endmodule // aoss_ctrl_model

`default_nettype wire

// File: dv/aoss_chan_bench.sv
// Self-checking bench for the channel controller: APB register tasks plus controller model.
// Assumes TICK_CYCLES shortened to 10, so one second of fault hold is 10000 cycles.
`default_nettype none

module aoss_chan_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import aoss_pkg::*;

  localparam int TC = 10;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic limit_hit = 0, open_load_seen = 0, err;
  logic [15:0] out_value;
  logic [2:0] out_range, rc[6];
  logic out_enable, limit_alarm, ramp_alarm, open_load_alarm, open_load_run;
  aoss_link_t link;
  aoss_cfg_t cfg;
  int mismatches = 0, checked = 0, cycles = 0;

  always #4 pclk = ~pclk;

  aoss_ctrl_model CTRL (.pclk(pclk), .link(link));
  aoss_chan #(.TICK_CYCLES(TC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link), .limit_hit(limit_hit), .open_load_seen(open_load_seen), .out_value(out_value),
    .out_range(out_range), .out_enable(out_enable), .limit_alarm(limit_alarm), .ramp_alarm(ramp_alarm),
    .open_load_alarm(open_load_alarm), .open_load_run(open_load_run));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard sized well above the 1 s fault hold plus setup traffic
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ends on a falling edge so outputs are settled when compared
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // One APB transfer; pready is sampled at the rising edge and the request released at that same edge
  // Only the hang guard ends a wait that never completes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wcfg();
    apb(1'b1, AOSS_CONFIG_ADDR, {13'h0000, cfg});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rc = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, AOSS_CONFIG_ADDR, '0);
    chk("config_reset", 32'h00000208, rd);
    apb(1'b0, AOSS_SLEW_ADDR, '0);
    chk("slew_reset", 32'h000F4240, rd);
    apb(1'b0, 8'h20, '0);
    chk("unmapped_err", 32'h00000001, {31'h0, err});
    cfg = AOSS_CFG_RESET;
    foreach (rc[i]) begin
      cfg.range = rc[i];
      wcfg();
      cyc(3);
      chk("out_range", {29'h0, rc[i]}, {29'h0, out_range});
      chk("out_enable", {31'h0, (i < 5)}, {31'h0, out_enable});
    end
    cfg.range = AOSS_RANGE_0_10V;
    cfg.chan_disable = 1'b1;
    wcfg();
    cyc(3);
    chk("disabled_enable", 32'h0, {31'h0, out_enable});
    cfg.chan_disable = 1'b0;
    cfg.fault_action = 1'b0;
    cfg.fault_hold_time = AOSS_HOLD_1S;
    wcfg();
    apb(1'b1, AOSS_FAULT_VAL_ADDR, 32'h00004000);
    apb(1'b1, AOSS_FINAL_VAL_ADDR, 32'h00000800);
    apb(1'b1, AOSS_PROG_VAL_ADDR, 32'h00002222);
    CTRL.put(1'b1, 1'b1, 1'b0, 16'h1234);
    cyc(4);
    chk("run_direct", 32'h1234, {16'h0, out_value});
    CTRL.put(1'b1, 1'b0, 1'b0, 16'h1234);
    cyc(4);
    chk("fault_value", 32'h4000, {16'h0, out_value});
    cyc(1000 * TC - 40);
    chk("fault_still", 32'h4000, {16'h0, out_value});
    cyc(60);
    chk("final_value", 32'h0800, {16'h0, out_value});
    CTRL.put(1'b1, 1'b1, 1'b0, 16'h1234);
    cyc(4);
    chk("reconnect", 32'h1234, {16'h0, out_value});
    cfg.program_action = 1'b0;
    wcfg();
    CTRL.put(1'b0, 1'b1, 1'b0, 16'h1234);
    cyc(4);
    chk("program_value", 32'h2222, {16'h0, out_value});
    CTRL.put(1'b0, 1'b0, 1'b0, 16'h1234);
    cyc(4);
    chk("prog_stays", 32'h2222, {16'h0, out_value});
    CTRL.put(1'b1, 1'b1, 1'b0, 16'h1234);
    cfg.program_action = 1'b1;
    wcfg();
    // New command only after inhibit is seen, so the hold has something to refuse
    CTRL.put(1'b1, 1'b1, 1'b1, 16'h1234);
    CTRL.put(1'b1, 1'b1, 1'b1, 16'h5555);
    cyc(4);
    chk("inhibit_hold", 32'h1234, {16'h0, out_value});
    CTRL.put(1'b1, 1'b1, 1'b0, 16'h1234);
    cfg.limit_alarm_latch_on = 1'b1;
    wcfg();
    @(posedge pclk) limit_hit <= 1'b1;
    @(posedge pclk) limit_hit <= 1'b0;
    cyc(3);
    chk("suppressed", 32'h0, {31'h0, limit_alarm});
    cfg.alarm_suppress = 1'b0;
    wcfg();
    @(posedge pclk) limit_hit <= 1'b1;
    @(posedge pclk) limit_hit <= 1'b0;
    cyc(5);
    chk("limit_latched", 32'h1, {31'h0, limit_alarm});
    apb(1'b1, AOSS_UNLATCH_ADDR, 32'h00000001);
    cyc(3);
    chk("limit_unlatched", 32'h0, {31'h0, limit_alarm});
    @(posedge pclk) open_load_seen <= 1'b1;
    cyc(3);
    chk("open_load_off", 32'h0, {30'h0, open_load_run, open_load_alarm});
    cfg.open_load_check_on = 1'b1;
    cfg.run_ramp_on = 1'b1;
    cfg.ramp_alarm_latch_on = 1'b1;
    wcfg();
    cyc(3);
    chk("open_load_on", 32'h3, {30'h0, open_load_run, open_load_alarm});
    // Step of 10 codes per tick from a rate of 10000 codes per second
    apb(1'b1, AOSS_SLEW_ADDR, 32'h00002710);
    CTRL.put(1'b1, 1'b1, 1'b0, 16'h5234);
    cyc(5 * TC);
    chk("ramp_limited", 32'h1, {31'h0, (out_value > 16'h124C && out_value < 16'h1284)});
    chk("ramp_alarm", 32'h1, {31'h0, ramp_alarm});
    apb(1'b1, AOSS_SLEW_ADDR, 32'h00000000);
    cyc(3 * TC);
    chk("ramp_zero_rate", 32'h5234, {16'h0, out_value});
    // Ramp has ended, so only the latch keeps the alarm up
    chk("ramp_latched", 32'h1, {31'h0, ramp_alarm});
    apb(1'b1, AOSS_UNLATCH_ADDR, 32'h00000002);
    cyc(3);
    chk("ramp_unlatched", 32'h0, {31'h0, ramp_alarm});
    cfg.run_ramp_on = 1'b0;
    cfg.hold_until_match = 1'b1;
    wcfg();
    CTRL.put(1'b0, 1'b1, 1'b0, 16'h5234);
    CTRL.put(1'b1, 1'b1, 1'b0, 16'h7000);
    cyc(4);
    chk("init_hold", 32'h5234, {16'h0, out_value});
    CTRL.put(1'b1, 1'b1, 1'b0, 16'h5260);
    cyc(4);
    chk("init_match", 32'h5260, {16'h0, out_value});
    conclude();
  end
endmodule // aoss_chan_bench

`default_nettype wire
